// ===== hdl/tape_fe_map.svh
// offsets, field positions, codes and reset values of the tape command front end
`ifndef TAPE_FE_MAP_SVH
`define TAPE_FE_MAP_SVH

// ************************************************************
// register offsets (byte addresses on the register port)
// ************************************************************
`define RA_POINTER        4'h0
`define RA_STATUS         4'h4
`define RA_CONFIG         4'h8
`define RA_CHARS          4'hC

// ************************************************************
// field positions
// ************************************************************
`define ST_PASS           0
`define ST_REJECT         1
`define ST_MSG_SET        4
`define ST_READY          7
`define ST_A16            8
`define ST_A17            9
`define CFG_EXT           0
`define CFG_BLOCK         1
`define CFG_RESET         2'h0

// ************************************************************
// packet command word: class in [3:0], mode in [11:8]
// ************************************************************
`define CMD_GET_STATUS    4'h1
`define CMD_READ          4'h2
`define CMD_WRITE_CHAR    4'h3
`define CMD_WRITE         4'h4
`define CMD_POSITION      4'h5
`define CMD_FORMAT        4'h6
`define CMD_CONTROL       4'h7
`define CMD_INIT          4'h8
`define CMD_WRITE_SUBMEM  4'h9
`define MODE_READ_NEXT    4'h0
`define MODE_WRITE_RETRY  4'h1
`define MODE_SPACE_REV    4'h1
`define MODE_SKIP_REV     4'h3
`define MODE_TM_RETRY     4'h2

// ************************************************************
// limits, message codes, self-test pattern
// ************************************************************
`define REV_LIMIT         16'h0008
`define MSG_DONE          8'h01
`define MSG_ERROR         8'h02
`define MSG_REJECT        8'h03
`define MSG_LEN_WORD      16'h0006
`define TEST_PATTERN      16'hA55A

`endif

// ===== hdl/tape_fe_pkg.sv
// types shared by the tape command front end and its record buffer
`default_nettype none
package tape_fe_pkg;

	// one-hot sequencer states
	typedef enum logic [7:0] {
		S_SELFTEST = 8'h01,
		S_IDLE     = 8'h02,
		S_FETCH    = 8'h04,
		S_DECODE   = 8'h08,
		S_XFER     = 8'h10,
		S_DRIVE    = 8'h20,
		S_MSG      = 8'h40,
		S_DONE     = 8'h80
	} fe_state_type;

	typedef struct packed {
		logic        wr;
		logic        rd;
		logic [3:0]  addr;
		logic [15:0] wdata;
	} reg_req_type;

	typedef struct packed {
		logic        req;
		logic        we;
		logic        byte_xfer;
		logic        block;
		logic [21:0] addr;
		logic [15:0] wdata;
	} dma_req_type;

	typedef struct packed {
		logic        start;
		logic [3:0]  cmd;
		logic [3:0]  mode;
		logic [15:0] count;
	} func_req_type;

	typedef struct packed {
		logic [1:0]  we;
		logic [13:0] addr;
		logic [15:0] wdata;
	} buf_port_type;

	typedef struct packed {
		fe_state_type      state;
		logic [21:0]       bap;
		logic [3:0]        ext_hi;
		logic              ext22;
		logic [1:0]        cfg;
		logic [21:0]       msg_addr;
		logic              msg_set;
		logic [15:0]       chars;
		logic [3:0][15:0]  pkt;
		logic [1:0]        widx;
		logic [15:0]       rem;
		logic [13:0]       boff;
		logic [1:0]        phase;
		logic              rdir;
		logic              rej;
		logic [7:0]        code;
		logic [15:0]       residual;
		logic              start;
		logic              pass;
		logic [15:0]       rdata;
	} fe_regs_type;

endpackage
`default_nettype wire

// ===== hdl/record_buffer.sv
// dual-port 16K byte record staging buffer, byte write enables, registered reads
`timescale 1ns/1ps
`default_nettype none

module record_buffer (
	// clock
	input  wire logic                      i_core_clk,
	// front end port
	input  wire tape_fe_pkg::buf_port_type i_port_a,
	output logic [15:0]                    o_rdata_a,
	// drive sequencer port
	input  wire tape_fe_pkg::buf_port_type i_port_b,
	output logic [15:0]                    o_rdata_b
);

	logic [15:0] mem [0:8191];
	logic [15:0] rd_a_q;
	logic [15:0] rd_b_q;

	// byte lanes written per port; a read follows the word address
	always_ff @(posedge i_core_clk) begin
		if (i_port_a.we[0]) begin
			mem[i_port_a.addr[13:1]][7:0] <= i_port_a.wdata[7:0];
		end
		if (i_port_a.we[1]) begin
			mem[i_port_a.addr[13:1]][15:8] <= i_port_a.wdata[15:8];
		end
		if (i_port_b.we[0]) begin
			mem[i_port_b.addr[13:1]][7:0] <= i_port_b.wdata[7:0];
		end
		if (i_port_b.we[1]) begin
			mem[i_port_b.addr[13:1]][15:8] <= i_port_b.wdata[15:8];
		end
		rd_a_q <= mem[i_port_a.addr[13:1]];
		rd_b_q <= mem[i_port_b.addr[13:1]];
	end

	assign o_rdata_a = rd_a_q;
	assign o_rdata_b = rd_b_q;

endmodule

`default_nettype wire

// ===== hdl/tape_command_packet_front_end.sv
// command packet front end: pointer port, packet fetch, decode, data dma, messages
//
// Overview of operation
// [RULE1] a packet is built by the host first; all four words are always fetched
// [RULE2] word two gives address 15..0; word three bits 1..0 give address 17..16
// [RULE3] extended mode after status high byte load: word three bits 5..2 give 21..18
// [RULE4] count comes from offset 6 for data commands, offset 2 otherwise
// [RULE5] host places packets on addresses divisible by four
// [RULE6] command word decoded; only valid commands start a function
// [RULE7] data pointer goes into the bus address pointer for data dma
// [RULE8] count means bytes, records or files depending on the command
// [RULE9] status word is changed by internal logic only, never by host writes
// [RULE10] after initialize only the characteristics command is accepted first
// [RULE11] characteristics command stores message buffer address and characteristics
// [RULE12] write retry, tape mark retry and memory write diagnostics are rejected
// [RULE13] read previous, reread previous and reread next are rejected
// [RULE14] get status refreshes the extended status word in the message buffer
// [RULE15] reverse spacing and skipping are limited per command
// [RULE16] bus address pointer points at buffers, then runs during data transfer
// [RULE17] 22-bit addresses with extended features, 18-bit otherwise
// [RULE18] no bus parity is generated or checked
// [RULE19] any command on a 300 foot tape ends in a rejection
// [RULE20] self-test at power-up; indicator stays lit once it passes
// [RULE21] block mode dma only when the block mode option is set
// [RULE22] records are staged in a 16K byte on-board buffer
// [RULE23] results are reported by message packets in host memory
// [RULE24] pointer write loads 15..2 direct, 17..16 from bits 1..0, low bits zero
// [RULE25] address advances by two per word and by one per byte
// [RULE26] a bus interrupt follows the finished message packet
//
// The register addresses and strobed register access were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "tape_fe_map.svh"

module tape_command_packet_front_end (
	// clock and reset
	input  wire logic                      i_core_clk,
	input  wire logic                      i_srst,
	// register port
	input  wire tape_fe_pkg::reg_req_type  i_reg,
	output logic [15:0]                    o_reg_rdata,
	// host bus dma master
	output tape_fe_pkg::dma_req_type       o_dma,
	input  wire logic                      i_dma_ack,
	input  wire logic [15:0]               i_dma_rdata,
	// drive sequencer
	output tape_fe_pkg::func_req_type      o_func,
	input  wire logic                      i_func_done,
	input  wire logic                      i_func_error,
	input  wire logic [15:0]               i_func_residual,
	input  wire logic [15:0]               i_ext_status,
	input  wire logic                      i_tape_300ft,
	// drive side of record buffer
	input  wire tape_fe_pkg::buf_port_type i_drv_buf,
	output logic [15:0]                    o_drv_buf_rdata,
	// status outputs
	output logic                           o_bus_irq,
	output logic                           o_led
);

	tape_fe_pkg::fe_regs_type  s_q;
	tape_fe_pkg::fe_regs_type  s_d;
	tape_fe_pkg::buf_port_type buf_a;
	logic [15:0]               buf_rdata;
	logic [15:0]               status_w;
	logic [3:0]                cmd;
	logic [3:0]                mode;
	logic                      data_op;
	logic [15:0]               count;
	logic                      valid_cmd;
	logic                      rej_any;
	logic [21:0]               pkt_addr;
	logic                      word_xfer;
	logic [7:0]                host_byte;
	logic [7:0]                buf_byte;
	logic [15:0]               msg_word;

	// ************************************************************
	// record staging buffer
	// ************************************************************
	record_buffer u_buf (                         // [RULE22]
		.i_core_clk (i_core_clk),
		.i_port_a   (buf_a),
		.o_rdata_a  (buf_rdata),
		.i_port_b   (i_drv_buf),
		.o_rdata_b  (o_drv_buf_rdata)
	);

	// ************************************************************
	// decode of the fetched packet
	// ************************************************************

	// command fields and count selection
	assign cmd     = s_q.pkt[0][3:0];               // [RULE6]
	assign mode    = s_q.pkt[0][11:8];
	assign data_op = (cmd == `CMD_READ) || (cmd == `CMD_WRITE);
	assign count   = data_op ? s_q.pkt[3] : s_q.pkt[1]; // [RULE4]

	// packet address words into a host address
	assign pkt_addr = {((s_q.cfg[`CFG_EXT] && s_q.ext22) ? s_q.pkt[2][5:2] : 4'h0), // [RULE3]
		s_q.pkt[2][1:0], s_q.pkt[1]};             // [RULE2]

	// legal command classes
	assign valid_cmd = (cmd >= `CMD_GET_STATUS) && (cmd <= `CMD_WRITE_SUBMEM); // [RULE6]

	// every reason to refuse the command
	assign rej_any = !valid_cmd
		|| (!s_q.msg_set && (cmd != `CMD_WRITE_CHAR))                 // [RULE10]
		|| ((cmd == `CMD_WRITE) && (mode == `MODE_WRITE_RETRY))       // [RULE12]
		|| ((cmd == `CMD_FORMAT) && (mode == `MODE_TM_RETRY))         // [RULE12]
		|| (cmd == `CMD_WRITE_SUBMEM)                                 // [RULE12]
		|| ((cmd == `CMD_READ) && (mode != `MODE_READ_NEXT))          // [RULE13]
		|| ((cmd == `CMD_POSITION) && ((mode == `MODE_SPACE_REV)
			|| (mode == `MODE_SKIP_REV)) && (count > `REV_LIMIT))     // [RULE15]
		|| i_tape_300ft;                                              // [RULE19]

	// ************************************************************
	// data path helpers
	// ************************************************************

	// word moves need two bytes left and even addresses on both sides
	assign word_xfer = (s_q.rem >= 16'h0002) && !s_q.bap[0] && !s_q.boff[0];
	assign host_byte = s_q.bap[0] ? i_dma_rdata[15:8] : i_dma_rdata[7:0];
	assign buf_byte  = s_q.boff[0] ? buf_rdata[15:8] : buf_rdata[7:0];

	// message packet words
	always_comb begin
		case (s_q.widx)
			2'd0:    msg_word = {8'h00, s_q.code};
			2'd1:    msg_word = `MSG_LEN_WORD;
			2'd2:    msg_word = s_q.residual;
			default: msg_word = i_ext_status;          // [RULE14]
		endcase
	end

	// status word, built only from internal state
	always_comb begin
		status_w             = 16'h0000;            // [RULE9]
		status_w[`ST_PASS]   = s_q.pass;
		status_w[`ST_REJECT] = s_q.rej;
		status_w[`ST_MSG_SET] = s_q.msg_set;
		status_w[`ST_READY]  = (s_q.state == tape_fe_pkg::S_IDLE);
		status_w[`ST_A16]    = s_q.bap[16];
		status_w[`ST_A17]    = s_q.bap[17];
	end

	// ************************************************************
	// next state
	// ************************************************************
	always_comb begin
		s_d        = s_q;
		s_d.start  = 1'b0;
		s_d.rdata  = 16'h0000;
		buf_a      = '0;
		o_dma      = '0;
		o_dma.addr = s_q.cfg[`CFG_EXT] ? s_q.bap : {4'h0, s_q.bap[17:0]}; // [RULE17]
		// register reads answer in the next cycle only
		if (i_reg.rd) begin
			case (i_reg.addr)
				`RA_POINTER: s_d.rdata = s_q.bap[15:0];
				`RA_STATUS:  s_d.rdata = status_w;
				`RA_CONFIG:  s_d.rdata = {14'h0000, s_q.cfg};
				`RA_CHARS:   s_d.rdata = s_q.chars;
				default:     s_d.rdata = 16'h0000;
			endcase
		end
		// configuration and the status high byte (latches upper address and the ext22 flag)
		if (i_reg.wr && (i_reg.addr == `RA_CONFIG)) begin
			s_d.cfg = i_reg.wdata[1:0];
		end
		if (i_reg.wr && (i_reg.addr == `RA_STATUS)) begin
			s_d.ext_hi = i_reg.wdata[11:8];           // [RULE3]
			s_d.ext22  = s_q.cfg[`CFG_EXT];
		end
		case (s_q.state)
			tape_fe_pkg::S_SELFTEST: begin
				// write, read back and compare one buffer word
				buf_a.addr = 14'h0000;
				case (s_q.phase)
					2'd0: begin
						buf_a.we    = 2'b11;
						buf_a.wdata = `TEST_PATTERN;
						s_d.phase   = 2'd1;
					end
					2'd1: s_d.phase = 2'd2;
					default: begin
						s_d.pass  = (buf_rdata == `TEST_PATTERN); // [RULE20]
						s_d.phase = 2'd0;
						s_d.state = tape_fe_pkg::S_IDLE;
					end
				endcase
			end
			tape_fe_pkg::S_IDLE: begin
				if (i_reg.wr && (i_reg.addr == `RA_POINTER)) begin
					s_d.bap[15:2]  = i_reg.wdata[15:2];   // [RULE24]
					s_d.bap[17:16] = i_reg.wdata[1:0];    // [RULE24]
					s_d.bap[1:0]   = 2'b00;               // [RULE5]
					s_d.bap[21:18] = s_q.cfg[`CFG_EXT] ? s_q.ext_hi : 4'h0; // [RULE3]
					s_d.widx       = 2'd0;
					s_d.rej        = 1'b0;
					s_d.state      = tape_fe_pkg::S_FETCH;
				end
			end
			tape_fe_pkg::S_FETCH: begin
				// bus address pointer walks the command packet
				o_dma.req = 1'b1;                         // [RULE16]
				if (i_dma_ack) begin
					s_d.pkt[s_q.widx] = i_dma_rdata;
					s_d.bap           = s_q.bap + 22'd2;  // [RULE25]
					s_d.widx          = s_q.widx + 2'd1;
					if (s_q.widx == 2'd3) begin
						s_d.state = tape_fe_pkg::S_DECODE; // [RULE1]
					end
				end
			end
			tape_fe_pkg::S_DECODE: begin
				s_d.widx     = 2'd0;
				s_d.residual = 16'h0000;
				s_d.code     = `MSG_DONE;
				s_d.rdir     = (cmd == `CMD_READ);
				s_d.rem      = count;                     // [RULE8]
				s_d.boff     = 14'h0000;
				s_d.phase    = 2'd0;
				if (rej_any) begin
					s_d.rej   = 1'b1;
					s_d.code  = `MSG_REJECT;
					s_d.bap   = s_q.msg_addr;
					s_d.state = s_q.msg_set ? tape_fe_pkg::S_MSG : tape_fe_pkg::S_DONE;
				end else if (cmd == `CMD_WRITE_CHAR) begin
					s_d.msg_addr = pkt_addr;              // [RULE11]
					s_d.chars    = s_q.pkt[3];            // [RULE11]
					s_d.msg_set  = 1'b1;
					s_d.bap      = pkt_addr;
					s_d.state    = tape_fe_pkg::S_MSG;
				end else if (cmd == `CMD_GET_STATUS) begin
					s_d.bap   = s_q.msg_addr;             // [RULE14]
					s_d.state = tape_fe_pkg::S_MSG;
				end else if (cmd == `CMD_WRITE) begin
					s_d.bap   = pkt_addr;                 // [RULE7]
					s_d.state = tape_fe_pkg::S_XFER;
				end else begin
					// reads and non-data commands go to the drive first
					s_d.bap   = data_op ? pkt_addr : s_q.bap; // [RULE7]
					s_d.start = 1'b1;                     // [RULE8]
					s_d.state = tape_fe_pkg::S_DRIVE;
				end
			end
			tape_fe_pkg::S_XFER: begin
				buf_a.addr = s_q.boff;
				if (s_q.rem == 16'h0000) begin
					if (s_q.rdir) begin
						s_d.bap   = s_q.msg_addr;
						s_d.state = tape_fe_pkg::S_MSG;
					end else begin
						s_d.start = 1'b1;
						s_d.state = tape_fe_pkg::S_DRIVE;
					end
				end else if (!s_q.rdir) begin
					// host memory to buffer
					o_dma.req       = 1'b1;
					o_dma.byte_xfer = !word_xfer;
					o_dma.block     = s_q.cfg[`CFG_BLOCK] && word_xfer; // [RULE21]
					if (i_dma_ack) begin
						buf_a.we    = word_xfer ? 2'b11 : (s_q.boff[0] ? 2'b10 : 2'b01);
						buf_a.wdata = word_xfer ? i_dma_rdata : {host_byte, host_byte};
					end
				end else if (s_q.phase == 2'd0) begin
					// buffer word must be read before the host write
					s_d.phase = 2'd1;
				end else begin
					o_dma.req       = 1'b1;
					o_dma.we        = 1'b1;
					o_dma.byte_xfer = !word_xfer;
					o_dma.block     = s_q.cfg[`CFG_BLOCK] && word_xfer; // [RULE21]
					o_dma.wdata     = word_xfer ? buf_rdata : {buf_byte, buf_byte};
					if (i_dma_ack) begin
						s_d.phase = 2'd0;
					end
				end
				if (o_dma.req && i_dma_ack) begin
					s_d.bap  = s_q.bap + (word_xfer ? 22'd2 : 22'd1); // [RULE25]
					s_d.boff = s_q.boff + (word_xfer ? 14'd2 : 14'd1);
					s_d.rem  = s_q.rem - (word_xfer ? 16'd2 : 16'd1);
				end
			end
			tape_fe_pkg::S_DRIVE: begin
				if (i_func_done) begin
					s_d.residual = i_func_residual;
					s_d.code     = i_func_error ? `MSG_ERROR : `MSG_DONE;
					if (s_q.rdir && !i_func_error) begin
						s_d.state = tape_fe_pkg::S_XFER;
					end else begin
						s_d.bap   = s_q.msg_addr;
						s_d.state = tape_fe_pkg::S_MSG;
					end
				end
			end
			tape_fe_pkg::S_MSG: begin
				// four word message packet into the host buffer
				o_dma.req   = 1'b1;                       // [RULE23]
				o_dma.we    = 1'b1;
				o_dma.wdata = msg_word;
				if (i_dma_ack) begin
					s_d.bap  = s_q.bap + 22'd2;           // [RULE25]
					s_d.widx = s_q.widx + 2'd1;
					if (s_q.widx == 2'd3) begin
						s_d.state = tape_fe_pkg::S_DONE;
					end
				end
			end
			tape_fe_pkg::S_DONE: begin
				s_d.state = tape_fe_pkg::S_IDLE;
			end
			default: begin
				s_d.state = tape_fe_pkg::S_IDLE;
			end
		endcase
	end

	// ************************************************************
	// state register
	// ************************************************************
	always_ff @(posedge i_core_clk) begin
		if (i_srst) begin
			s_q       <= '0;
			s_q.state <= tape_fe_pkg::S_SELFTEST;
			s_q.cfg   <= `CFG_RESET;
		end else begin
			s_q <= s_d;
		end
	end

	// ************************************************************
	// outputs (host bus data carries no parity)
	// ************************************************************
	assign o_reg_rdata  = s_q.rdata;                // [RULE18]
	assign o_func.start = s_q.start;
	assign o_func.cmd   = cmd;
	assign o_func.mode  = mode;
	assign o_func.count = count;                    // [RULE8]
	assign o_bus_irq    = (s_q.state == tape_fe_pkg::S_DONE); // [RULE26]
	assign o_led        = s_q.pass;                 // [RULE20]

	// ************************************************************
	// assertions
	// ************************************************************
	logic [2:0] fetch_cnt_q;

	// counts packet words taken since the pointer write
	always_ff @(posedge i_core_clk) begin
		if (i_srst || (s_q.state == tape_fe_pkg::S_IDLE)) begin
			fetch_cnt_q <= 3'd0;
		end else if ((s_q.state == tape_fe_pkg::S_FETCH) && i_dma_ack) begin
			fetch_cnt_q <= fetch_cnt_q + 3'd1;
		end
	end

	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (i_srst);

	sequence s_ptr_write;
		(s_q.state == tape_fe_pkg::S_IDLE) && i_reg.wr && (i_reg.addr == `RA_POINTER);
	endsequence

	sequence s_msg_last;
		(s_q.state == tape_fe_pkg::S_MSG) && i_dma_ack && (s_q.widx == 2'd3);
	endsequence

	chk_ptr_load: assert property (s_ptr_write |=> (s_q.bap[1:0] == 2'b00) // [RULE24]
		&& (s_q.bap[17:16] == $past(i_reg.wdata[1:0]))
		&& (s_q.bap[15:2] == $past(i_reg.wdata[15:2])) ##1 (s_q.state == tape_fe_pkg::S_FETCH))
		else $error("pointer write loaded wrong address");
	chk_fetch_four: assert property ((s_q.state == tape_fe_pkg::S_DECODE) |-> fetch_cnt_q == 3'd4) // [RULE1]
		else $error("decode entered without four packet words");
	chk_status_ro: assert property (((s_q.state == tape_fe_pkg::S_IDLE) && i_reg.wr // [RULE9]
		&& (i_reg.addr == `RA_STATUS)) |=> $stable(status_w))
		else $error("host write changed status word");
	chk_addr_width: assert property ((o_dma.req && !s_q.cfg[`CFG_EXT]) // [RULE17]
		|-> (o_dma.addr[21:18] == 4'h0))
		else $error("upper address driven without extended features");
	chk_block_mode: assert property (o_dma.block |-> s_q.cfg[`CFG_BLOCK]) // [RULE21]
		else $error("block mode used while disabled");
	chk_fetch_step: assert property (((s_q.state == tape_fe_pkg::S_FETCH) && i_dma_ack) // [RULE25]
		|=> (s_q.bap == $past(s_q.bap) + 22'd2))
		else $error("fetch address did not advance by two");
	chk_first_cmd: assert property (((s_q.state == tape_fe_pkg::S_DECODE) && !s_q.msg_set // [RULE10]
		&& (cmd != `CMD_WRITE_CHAR)) |=> s_q.rej && (s_q.state == tape_fe_pkg::S_DONE))
		else $error("command accepted before message buffer set");
	chk_diag_reject: assert property (((s_q.state == tape_fe_pkg::S_DECODE) // [RULE12]
		&& (cmd == `CMD_WRITE_SUBMEM)) |=> s_q.rej && (s_q.code == `MSG_REJECT))
		else $error("memory write diagnostic not rejected");
	chk_irq_after: assert property (s_msg_last |=> o_bus_irq ##1 // [RULE26]
		(!o_bus_irq && (s_q.state == tape_fe_pkg::S_IDLE)))
		else $error("interrupt missing after message packet");
	chk_led_hold: assert property (o_led |=> o_led) // [RULE20]
		else $error("indicator dropped after self-test pass");

endmodule

`default_nettype wire

// ===== test/host_mem_model.sv
// host memory model answering the front end's dma requests
`timescale 1ns/1ps
`default_nettype none

module host_mem_model (
	// clock
	input  wire logic                     i_core_clk,
	// dma slave side
	input  wire tape_fe_pkg::dma_req_type i_dma,
	input  wire logic [3:0]               i_ack_wait,
	output logic                          o_dma_ack,
	output logic [15:0]                   o_dma_rdata
);
	logic [15:0] mem [logic [20:0]];
	logic [3:0]  wait_q = 4'h0;
	logic [20:0] wa;

	// word index of the requested byte address
	assign wa = i_dma.addr[21:1];

	// one answer per held request after i_ack_wait idle cycles
	always @(posedge i_core_clk) begin
		o_dma_ack <= 1'b0;
		o_dma_rdata <= ~o_dma_rdata; // released lines never hold old data
		if (i_dma.req === 1'b1 && o_dma_ack !== 1'b1) begin
			if (wait_q < i_ack_wait) begin
				wait_q <= wait_q + 4'h1;
			end else begin
				wait_q <= 4'h0;
				o_dma_ack <= 1'b1;
				o_dma_rdata <= mem.exists(wa) ? mem[wa] : 16'h0000;
				if (i_dma.we && !i_dma.byte_xfer)
					mem[wa] = i_dma.wdata;
				if (i_dma.we && i_dma.byte_xfer)
					mem[wa] = i_dma.addr[0] ? {i_dma.wdata[7:0], mem[wa][7:0]}
						: {mem[wa][15:8], i_dma.wdata[7:0]};
			end
		end
	end

	// quiet start
	initial begin
		o_dma_ack = 1'b0;
		o_dma_rdata = 16'h0000;
	end
endmodule
`default_nettype wire

// ===== test/tb.sv
// bench for the tape command packet front end
`timescale 1ns/1ps
`default_nettype none
`include "tape_fe_map.svh"
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin failures++; $display("[FAIL] %0t got %h exp %h", $time, (g), (e)); end end

module tb;
	logic                      i_core_clk = 1'b0;
	logic                      i_srst     = 1'b1;
	tape_fe_pkg::reg_req_type  reg_q      = '0;
	tape_fe_pkg::buf_port_type drv_q      = '0;
	tape_fe_pkg::dma_req_type  dma;
	tape_fe_pkg::func_req_type func;
	logic [15:0]               reg_rdata;
	logic [15:0]               dma_rdata;
	logic [15:0]               buf_rdata;
	logic                      dma_ack;
	logic                      func_done  = 1'b0;
	logic                      func_err   = 1'b0;
	logic                      tape_300   = 1'b0;
	logic [15:0]               resid      = 16'h0007;
	logic [15:0]               ext_stat   = 16'h5a3c;
	logic                      irq;
	logic                      led;
	logic [3:0]                ack_wait   = 4'h0;
	logic [15:0]               v;
	logic [15:0]               s;
	int                        fcnt       = 0;
	int                        failures   = 0;
	int                        cmp_count  = 0;
	logic [15:0]               tw [10]    = '{16'h0102, 16'h0202, 16'h0302, 16'h0104,
		16'h0206, 16'h0009, 16'h0105, 16'h0105, 16'h0305, 16'h0000};
	logic [15:0]               tc [10]    = '{16'h0001, 16'h0001, 16'h0001, 16'h0001,
		16'h0001, 16'h0001, 16'h0009, 16'h0008, 16'h0009, 16'h0001};

	tape_command_packet_front_end i_tape_command_packet_front_end (.i_core_clk(i_core_clk),
		.i_srst(i_srst), .i_reg(reg_q), .o_reg_rdata(reg_rdata), .o_dma(dma),
		.i_dma_ack(dma_ack), .i_dma_rdata(dma_rdata), .o_func(func), .i_func_done(func_done),
		.i_func_error(func_err), .i_func_residual(resid), .i_ext_status(ext_stat),
		.i_tape_300ft(tape_300), .i_drv_buf(drv_q), .o_drv_buf_rdata(buf_rdata),
		.o_bus_irq(irq), .o_led(led));
	host_mem_model i_host_mem_model (.i_core_clk(i_core_clk), .i_dma(dma),
		.i_ack_wait(ack_wait), .o_dma_ack(dma_ack), .o_dma_rdata(dma_rdata));

	// 10 MHz clock
	always #50 i_core_clk = ~i_core_clk;

	// drive stand-in: each function ends four cycles after it starts
	always @(posedge i_core_clk) begin
		func_done <= (fcnt == 1);
		fcnt <= (func.start === 1'b1) ? 4 : (fcnt != 0 ? fcnt - 1 : 0);
	end

	function automatic logic [15:0] mw(input logic [21:0] ba);
		return i_host_mem_model.mem[ba[21:1]];
	endfunction

	task automatic reg_acc(input logic w, input logic [3:0] a, input logic [15:0] d);
		@(posedge i_core_clk);
		reg_q <= '{wr: w, rd: !w, addr: a, wdata: d};
		@(posedge i_core_clk);
		reg_q <= '0;
		#1 v = reg_rdata;
	endtask

	// host builds the whole packet before handing over its pointer
	task automatic run_cmd(input logic [15:0] p, input logic [21:0] ba,
		input logic [15:0] w0, w1, w2, w3);
		int n;
		n = 0;
		i_host_mem_model.mem[ba[21:1]] = w0;
		i_host_mem_model.mem[ba[21:1] + 21'h1] = w1;
		i_host_mem_model.mem[ba[21:1] + 21'h2] = w2;
		i_host_mem_model.mem[ba[21:1] + 21'h3] = w3;
		reg_acc(1'b1, `RA_POINTER, p);
		while (irq !== 1'b1 && n < 3000) begin
			@(posedge i_core_clk);
			#1 n++;
		end
		if (n >= 3000) begin
			failures++;
			tally_and_finish();
		end
		repeat (2) @(posedge i_core_clk);
	endtask

	task automatic tally_and_finish();
		$display("compares %0d mismatches %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	// main sequence
	initial begin
		repeat (2) @(posedge i_core_clk);
		i_srst <= 1'b0;
		repeat (6) @(posedge i_core_clk);
		reg_acc(1'b0, `RA_STATUS, 16'h0000);
		`CHK({led, v[7], v[0]}, 3'b111)
		i_host_mem_model.mem[21'h1000] = 16'hdead;
		run_cmd(16'h1000, 22'h1000, 16'h0001, 16'h0000, 16'h0000, 16'h0000);
		reg_acc(1'b0, `RA_STATUS, 16'h0000);
		s = v;
		`CHK({v[1], mw(22'h2000)}, {1'b1, 16'hdead})
		reg_acc(1'b1, `RA_STATUS, 16'hffff);
		reg_acc(1'b0, `RA_STATUS, 16'h0000);
		`CHK(v, s)
		$display("reset and first command done");
		run_cmd(16'h1004, 22'h1004, 16'h0003, 16'h2000, 16'h0000, 16'h00ab);
		`CHK({mw(22'h2000), mw(22'h2002)}, 32'h0001_0006)
		reg_acc(1'b0, `RA_CHARS, 16'h0000);
		`CHK(v, 16'h00ab)
		@(posedge i_core_clk);
		ext_stat <= 16'hc3a5;
		i_host_mem_model.mem[21'h1000] = 16'h0000;
		run_cmd(16'h1009, 22'h1_1008, 16'h0001, 16'h0000, 16'h0000, 16'h0000);
		`CHK({mw(22'h2000), mw(22'h2006)}, {16'h0001, ext_stat})
		$display("characteristics and status done");
		for (int k = 0; k < 10; k++) begin
			ack_wait <= k[0] ? 4'h3 : 4'h0;
			run_cmd(16'h1010, 22'h1010, tw[k], tc[k], 16'h0000, tc[k]);
			`CHK(mw(22'h2000), (k == 7) ? 16'h0001 : 16'h0003)
		end
		tape_300 <= 1'b1;
		run_cmd(16'h1010, 22'h1010, 16'h0001, 16'h0000, 16'h0000, 16'h0000);
		`CHK(mw(22'h2000), 16'h0003)
		tape_300 <= 1'b0;
		func_err <= 1'b1;
		run_cmd(16'h1010, 22'h1010, 16'h0005, 16'h0001, 16'h0000, 16'h0001);
		`CHK({mw(22'h2000), mw(22'h2004)}, 32'h0002_0007)
		func_err <= 1'b0;
		$display("rejection table done");
		drv_q <= '{we: 2'b11, addr: 14'h0000, wdata: 16'h1234};
		@(posedge i_core_clk);
		drv_q <= '{we: 2'b11, addr: 14'h0002, wdata: 16'h5678};
		@(posedge i_core_clk);
		drv_q <= '0;
		i_host_mem_model.mem[21'h0_9800] = 16'h0000;
		i_host_mem_model.mem[21'h0_9801] = 16'hff00;
		i_host_mem_model.mem[21'h0_9802] = 16'hbeef;
		run_cmd(16'h1014, 22'h1014, 16'h0002, 16'h3000, 16'h0001, 16'h0003);
		`CHK({func.mode, func.cmd, func.count}, 24'h02_0003)
		`CHK({mw(22'h1_3000), mw(22'h1_3002), mw(22'h1_3004)}, 48'h1234_ff78_beef)
		reg_acc(1'b1, `RA_CONFIG, 16'h0002);
		reg_acc(1'b0, `RA_CONFIG, 16'h0000);
		`CHK(v, 16'h0002)
		i_host_mem_model.mem[21'h0_9800] = 16'h9abc;
		run_cmd(16'h1018, 22'h1018, 16'h0004, 16'h3000, 16'h0001, 16'h0002);
		repeat (2) @(posedge i_core_clk);
		`CHK(buf_rdata, 16'h9abc)
		$display("data transfers done");
		reg_acc(1'b1, `RA_CONFIG, 16'h0001);
		reg_acc(1'b1, `RA_STATUS, 16'h0100);
		run_cmd(16'h1000, 22'h4_1000, 16'h0003, 16'h2000, 16'h0004, 16'h00cd);
		`CHK(mw(22'h4_2000), 16'h0001)
		reg_acc(1'b0, `RA_CHARS, 16'h0000);
		`CHK(v, 16'h00cd)
		$display("extended addressing done");
		tally_and_finish();
	end
endmodule
`default_nettype wire
